// ===== qdcc_consts.svh
// Offsets, field positions, reset values and keys of the shared control
// registers of the four-channel converter.
// Assumes a serial front end that turns host frames into register strobes.
//
// What this block does
// - While locked, register writes other than the trigger key field are ignored until the unlock sequence.
// - Unlock: write key 0101 to trigger bits 15-12, then write lock bit 0.
// - Config bit 13 picks snapshot readback row: 0 is 0x00, 1 is 0x01.
// - Per channel power-down code resets to 11; current power-down resets to 1.
// - Writing 1010 to trigger bits 11-8 causes full reset; self-clears.
// - Trigger bit 7 loads outputs of channels opted into synchronous load.
// - Trigger bit 6 clears each channel to zero or mid code as selected.
// - Trigger bit 4 launches fault snapshot; self-clears.
// - Trigger bit 3 starts protective safe state; self-clears.
// - Trigger bit 2 reads one non-volatile row for snapshot; self-clears.
// - Trigger bit 1 programs settings into non-volatile memory; self-clears.
// - Trigger bit 0 restores non-volatile contents into registers; self-clears.
// - Channel flag-clear bits 15,11,7,3 reset that channel's comparator outputs.
// - Channel margin-low bits 14,10,6,2 issue margin-low; write 0 does nothing.
// - Channel margin-high bits 13,9,5,1 issue margin-high; write 0 does nothing.
// - Waveform-run bits 12,8,4,0 start generation at 1, stop at 0.
// - Read-only status: check fails, busy per channel, part and revision ids.
// - A busy channel refuses new commands; host waits for busy low.
`ifndef QDCC_CONSTS_SVH
`define QDCC_CONSTS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define QDCC_ADDR_CONFIG   8'h1f
`define QDCC_ADDR_TRIGGER  8'h20
`define QDCC_ADDR_CHTRIG   8'h21
`define QDCC_ADDR_STATUS   8'h22

// ----------------------------------------------------------------------
// Shared configuration word
// ----------------------------------------------------------------------
`define QDCC_CFG_RESET     16'h0fff
`define QDCC_CFG_WINLATCH  15
`define QDCC_CFG_LOCK      14
`define QDCC_CFG_ROWSEL    13
`define QDCC_CFG_INTREF    12
`define QDCC_PD_FIELD_W    3

// ----------------------------------------------------------------------
// Global trigger word
// ----------------------------------------------------------------------
`define QDCC_TRG_KEY_HI    15
`define QDCC_TRG_KEY_LO    12
`define QDCC_UNLOCK_KEY    4'h5
`define QDCC_TRG_RST_HI    11
`define QDCC_TRG_RST_LO    8
`define QDCC_RESET_KEY     4'ha
`define QDCC_TRG_LOAD      7
`define QDCC_TRG_CLEAR     6
`define QDCC_TRG_SNAP      4
`define QDCC_TRG_PROTECT   3
`define QDCC_TRG_ROWREAD   2
`define QDCC_TRG_NVPROG    1
`define QDCC_TRG_NVREST    0

// ----------------------------------------------------------------------
// Channel trigger word: channel c owns nibble starting at 12 - 4*c
// ----------------------------------------------------------------------
`define QDCC_CT_NIB_TOP    12
`define QDCC_CT_FLAGCLR    3
`define QDCC_CT_MARLO      2
`define QDCC_CT_MARHI      1
`define QDCC_CT_RUN        0

// ----------------------------------------------------------------------
// Status word
// ----------------------------------------------------------------------
`define QDCC_ST_FACTFAIL   15
`define QDCC_ST_USERFAIL   14
`define QDCC_ST_BUSY_LO    9
`define QDCC_ST_ID_LO      2

`endif

// ===== qdcc_pkg.sv
// Types shared by the control register block and its helpers.
// Assumes nothing beyond a single clock domain.
package qdcc_pkg;

  localparam int QDCC_NCH = 4;

  // Register strobe from the serial front end
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } qdcc_req_s;

  // Per-channel command pulses
  typedef struct packed {
    logic flag_clear;
    logic margin_low;
    logic margin_high;
  } qdcc_chcmd_s;

  // Lock state, Gray along open -> locked -> armed
  typedef enum logic [1:0] {
    QDCC_OPEN   = 2'b00,
    QDCC_LOCKED = 2'b01,
    QDCC_ARMED  = 2'b11
  } qdcc_lock_e;

endpackage

// ===== qdcc_lock.sv
// Register lock with key-armed unlock.
// Assumes strobes are one-cycle pulses from the register decoder.
`include "qdcc_consts.svh"
module qdcc_lock
  import qdcc_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic lock_set,
  input  wire logic key_ok,
  input  wire logic key_bad,
  input  wire logic cfg_wr,
  input  wire logic cfg_lock_val,
  input  wire logic load_valid,
  input  wire logic load_lock,
  output logic      locked
);

  qdcc_lock_e state;
  qdcc_lock_e next_state;

  // Next state; restore from storage overrides everything
  always_comb begin
    next_state = state;
    case (state)
      QDCC_OPEN: begin
        if (lock_set) next_state = QDCC_LOCKED;
      end
      QDCC_LOCKED: begin
        if (key_ok) next_state = QDCC_ARMED;
      end
      QDCC_ARMED: begin
        if (cfg_wr && !cfg_lock_val) next_state = QDCC_OPEN;
        else if (cfg_wr || key_bad) next_state = QDCC_LOCKED;
      end
      default: next_state = QDCC_LOCKED;
    endcase
    if (load_valid) next_state = load_lock ? QDCC_LOCKED : QDCC_OPEN;
  end

  // State and registered lock flag
  always_ff @(posedge clk) begin
    if (rst) begin
      state  <= QDCC_OPEN;
      locked <= 1'b0;
    end else begin
      state  <= next_state;
      locked <= (next_state != QDCC_OPEN);
    end
  end

endmodule

// ===== qdcc_chan.sv
// One channel's slice of the channel trigger word.
// Assumes busy comes from the channel's own sequencer.
`include "qdcc_consts.svh"
module qdcc_chan
  import qdcc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       wr,
  input  wire logic [3:0] nibble,
  input  wire logic       busy,
  output qdcc_chcmd_s     cmd,
  output logic            run
);

  logic take;

  // A busy channel takes no command at all
  assign take = wr && !busy;

  // One-cycle pulses; never stored, so readback is zero
  always_ff @(posedge clk) begin
    if (rst) begin
      cmd <= '0;
    end else begin
      cmd.flag_clear  <= take && nibble[`QDCC_CT_FLAGCLR];
      cmd.margin_low  <= take && nibble[`QDCC_CT_MARLO];
      cmd.margin_high <= take && nibble[`QDCC_CT_MARHI];
    end
  end

  // Waveform run level follows each accepted write
  always_ff @(posedge clk) begin
    if (rst) begin
      run <= 1'b0;
    end else if (take) begin
      run <= nibble[`QDCC_CT_RUN];
    end
  end

endmodule

// ===== qdcc_regs.sv
// Shared control and status registers of the four-channel converter.
// Assumes a serial front end that presents one-cycle read/write strobes,
// and channel, comparator and storage logic that consume the pulses.
`include "qdcc_consts.svh"
module qdcc_regs
  import qdcc_pkg::*;
#(
  parameter logic [5:0] PART_ID  = 6'h2a, // Arbitrary value
  parameter logic [1:0] REVISION = 2'h0   // Arbitrary value
)
(
  input  wire logic                clk,
  input  wire logic                rst,
  input  qdcc_req_s                req,
  output logic [15:0]              rdata,
  output logic                     rvalid,
  input  wire logic [QDCC_NCH-1:0] busy,
  input  wire logic [QDCC_NCH-1:0] sync_member,
  input  wire logic [QDCC_NCH-1:0] clear_value_select,
  input  wire logic                factory_store_check_fail,
  input  wire logic                user_store_check_fail,
  input  wire logic                nv_load_valid,
  input  wire logic [15:0]         nv_load_word,
  output logic                     window_latch_select,
  output logic                     snapshot_row_select,
  output logic                     int_ref_enable,
  output logic [2*QDCC_NCH-1:0]    voltage_powerdown_code,
  output logic [QDCC_NCH-1:0]      current_powerdown_bit,
  output logic                     register_lock_bit,
  output logic                     soft_reset_pulse,
  output logic [QDCC_NCH-1:0]      sync_load_pulse,
  output logic                     output_clear_pulse,
  output logic [QDCC_NCH-1:0]      clear_to_mid,
  output logic                     snapshot_start,
  output logic                     protect_start,
  output logic                     row_read_trigger,
  output logic                     nv_write_trigger,
  output logic                     nv_restore_trigger,
  output logic [QDCC_NCH-1:0]      comparator_flag_clear,
  output logic [QDCC_NCH-1:0]      margin_low_trigger,
  output logic [QDCC_NCH-1:0]      margin_high_trigger,
  output logic [QDCC_NCH-1:0]      waveform_run_bit
);

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  logic        soft_rst;
  logic        rst_all;
  logic        locked;
  logic        hit_cfg;
  logic        hit_trg;
  logic        hit_ct;
  logic        wr_cfg;
  logic        wr_trg;
  logic        wr_ct;
  logic [3:0]  key_val;
  logic [3:0]  rst_val;
  logic [15:0] cfg;
  logic [3:0]  key_field;
  qdcc_chcmd_s ch_cmd [QDCC_NCH];

  // A software reset reaches every register the next cycle, like power-on
  assign rst_all = rst || soft_rst;

  assign hit_cfg = (req.addr == `QDCC_ADDR_CONFIG);
  assign hit_trg = (req.addr == `QDCC_ADDR_TRIGGER);
  assign hit_ct  = (req.addr == `QDCC_ADDR_CHTRIG);
  assign key_val = req.wdata[`QDCC_TRG_KEY_HI:`QDCC_TRG_KEY_LO];
  assign rst_val = req.wdata[`QDCC_TRG_RST_HI:`QDCC_TRG_RST_LO];

  // Locked: only the key field and the final lock-clear write get through
  assign wr_cfg = req.wr && hit_cfg && !locked;
  assign wr_trg = req.wr && hit_trg && !locked;
  assign wr_ct  = req.wr && hit_ct && !locked;

  // ----------------------------------------------------------------------
  // Lock control
  // ----------------------------------------------------------------------
  qdcc_lock u_lock (
    .clk          (clk),
    .rst          (rst_all),
    .lock_set     (wr_cfg && req.wdata[`QDCC_CFG_LOCK]),
    .key_ok       (req.wr && hit_trg && key_val == `QDCC_UNLOCK_KEY),
    .key_bad      (req.wr && hit_trg && key_val != `QDCC_UNLOCK_KEY),
    .cfg_wr       (req.wr && hit_cfg),
    .cfg_lock_val (req.wdata[`QDCC_CFG_LOCK]),
    .load_valid   (nv_load_valid),
    .load_lock    (nv_load_word[`QDCC_CFG_LOCK]),
    .locked       (locked)
  );

  // ----------------------------------------------------------------------
  // Shared configuration word
  // ----------------------------------------------------------------------
  // Storage restore wins over a host write in the same cycle, since the
  // restore is a whole-map copy that the host asked for first
  always_ff @(posedge clk) begin
    if (rst_all) begin
      cfg <= `QDCC_CFG_RESET;
    end else if (nv_load_valid) begin
      cfg <= nv_load_word;
    end else if (wr_cfg) begin
      cfg <= req.wdata;
    end
  end

  // Registered copies of the configuration fields
  always_ff @(posedge clk) begin
    if (rst_all) begin
      window_latch_select <= 1'b0;
      snapshot_row_select <= 1'b0;
      int_ref_enable      <= 1'b0;
      register_lock_bit   <= 1'b0;
    end else begin
      window_latch_select <= cfg[`QDCC_CFG_WINLATCH];
      snapshot_row_select <= cfg[`QDCC_CFG_ROWSEL];
      int_ref_enable      <= cfg[`QDCC_CFG_INTREF];
      register_lock_bit   <= locked;
    end
  end

  // Power-down fields: channel c sits at bits 3c+2..3c
  genvar c;
  generate
    for (c = 0; c < QDCC_NCH; c++) begin : g_pd
      always_ff @(posedge clk) begin
        if (rst_all) begin
          voltage_powerdown_code[2*c+1:2*c] <= 2'h3;
          current_powerdown_bit[c]          <= 1'b1;
        end else begin
          voltage_powerdown_code[2*c+1:2*c] <=
            cfg[`QDCC_PD_FIELD_W*c+2:`QDCC_PD_FIELD_W*c+1];
          current_powerdown_bit[c] <= cfg[`QDCC_PD_FIELD_W*c];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Global trigger word
  // ----------------------------------------------------------------------
  // Only the key field is stored; every action bit is a pulse and reads 0
  always_ff @(posedge clk) begin
    if (rst_all) begin
      key_field <= 4'h0;
    end else if (req.wr && hit_trg) begin
      key_field <= key_val;
    end
  end

  // Software reset: one pulse, then the reset itself clears the request
  always_ff @(posedge clk) begin
    if (rst_all) begin
      soft_rst         <= 1'b0;
      soft_reset_pulse <= 1'b0;
    end else begin
      soft_rst         <= wr_trg && rst_val == `QDCC_RESET_KEY;
      soft_reset_pulse <= wr_trg && rst_val == `QDCC_RESET_KEY;
    end
  end

  // Synchronous load and clear: one pulse per write of a 1
  always_ff @(posedge clk) begin
    if (rst_all) begin
      sync_load_pulse    <= '0;
      output_clear_pulse <= 1'b0;
      clear_to_mid       <= '0;
    end else begin
      sync_load_pulse <= (wr_trg && req.wdata[`QDCC_TRG_LOAD])
                         ? sync_member : '0;
      output_clear_pulse <= wr_trg && req.wdata[`QDCC_TRG_CLEAR];
      clear_to_mid       <= clear_value_select;
    end
  end

  // Snapshot, protect and storage triggers, each a one-cycle pulse
  always_ff @(posedge clk) begin
    if (rst_all) begin
      snapshot_start     <= 1'b0;
      protect_start      <= 1'b0;
      row_read_trigger   <= 1'b0;
      nv_write_trigger   <= 1'b0;
      nv_restore_trigger <= 1'b0;
    end else begin
      snapshot_start     <= wr_trg && req.wdata[`QDCC_TRG_SNAP];
      protect_start      <= wr_trg && req.wdata[`QDCC_TRG_PROTECT];
      row_read_trigger   <= wr_trg && req.wdata[`QDCC_TRG_ROWREAD];
      nv_write_trigger   <= wr_trg && req.wdata[`QDCC_TRG_NVPROG];
      nv_restore_trigger <= wr_trg && req.wdata[`QDCC_TRG_NVREST];
    end
  end

  // ----------------------------------------------------------------------
  // Channel trigger word
  // ----------------------------------------------------------------------
  generate
    for (c = 0; c < QDCC_NCH; c++) begin : g_ch
      qdcc_chan u_chan (
        .clk    (clk),
        .rst    (rst_all),
        .wr     (wr_ct),
        .nibble (req.wdata[`QDCC_CT_NIB_TOP-4*c+3:`QDCC_CT_NIB_TOP-4*c]),
        .busy   (busy[c]),
        .cmd    (ch_cmd[c]),
        .run    (waveform_run_bit[c])
      );
      assign comparator_flag_clear[c] = ch_cmd[c].flag_clear;
      assign margin_low_trigger[c]    = ch_cmd[c].margin_low;
      assign margin_high_trigger[c]   = ch_cmd[c].margin_high;
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Readback
  // ----------------------------------------------------------------------
  logic [15:0] next_rdata;
  logic [15:0] ct_read;

  // Only run bits read back from the channel word
  always_comb begin
    ct_read = '0;
    for (int i = 0; i < QDCC_NCH; i++) begin
      ct_read[`QDCC_CT_NIB_TOP-4*i] = waveform_run_bit[i];
    end
  end

  // Read multiplexer; unmapped offsets read zero
  always_comb begin
    next_rdata = '0;
    case (req.addr)
      `QDCC_ADDR_CONFIG: begin
        next_rdata = cfg;
        next_rdata[`QDCC_CFG_LOCK] = locked;
      end
      `QDCC_ADDR_TRIGGER: begin
        next_rdata[`QDCC_TRG_KEY_HI:`QDCC_TRG_KEY_LO] = key_field;
      end
      `QDCC_ADDR_CHTRIG: begin
        next_rdata = ct_read;
      end
      `QDCC_ADDR_STATUS: begin
        next_rdata[`QDCC_ST_FACTFAIL] = factory_store_check_fail;
        next_rdata[`QDCC_ST_USERFAIL] = user_store_check_fail;
        next_rdata[`QDCC_ST_BUSY_LO+3:`QDCC_ST_BUSY_LO] = busy;
        next_rdata[`QDCC_ST_ID_LO+5:`QDCC_ST_ID_LO] = PART_ID;
        next_rdata[1:0] = REVISION;
      end
      default: next_rdata = '0;
    endcase
  end

  // Read data lands one cycle after the strobe and holds until the next
  always_ff @(posedge clk) begin
    if (rst_all) begin
      rdata  <= '0;
      rvalid <= 1'b0;
    end else begin
      rvalid <= req.rd;
      if (req.rd) rdata <= next_rdata;
    end
  end

endmodule

// ===== qdcc_regs_chk.sv
// Concurrent checks on the ports of the shared control register block.
// Assumes one clk domain; the lock port lags the lock state by one cycle.
`include "qdcc_consts.svh"
module qdcc_regs_chk
  import qdcc_pkg::*;
#(
  parameter logic [5:0] PART_ID  = 6'h2a,
  parameter logic [1:0] REVISION = 2'h0
)
(
  input  wire logic                clk,
  input  wire logic                rst,
  input  qdcc_req_s                req,
  input  wire logic [15:0]         rdata,
  input  wire logic [QDCC_NCH-1:0] busy,
  input  wire logic [QDCC_NCH-1:0] sync_member,
  input  wire logic                factory_store_check_fail,
  input  wire logic                user_store_check_fail,
  input  wire logic                register_lock_bit,
  input  wire logic                soft_reset_pulse,
  input  wire logic [QDCC_NCH-1:0] sync_load_pulse,
  input  wire logic                output_clear_pulse,
  input  wire logic                snapshot_start,
  input  wire logic                protect_start,
  input  wire logic [QDCC_NCH-1:0] comparator_flag_clear,
  input  wire logic [QDCC_NCH-1:0] margin_low_trigger,
  input  wire logic [QDCC_NCH-1:0] margin_high_trigger
);
  // ----------------------------------------------------------------
  // Write strobes
  // ----------------------------------------------------------------
  // The lock port shows, one cycle later, the lock state a write met
  wire w20 = req.wr && req.addr == `QDCC_ADDR_TRIGGER;
  wire w21 = req.wr && req.addr == `QDCC_ADDR_CHTRIG;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_LOAD: assert property (w20 |=> sync_load_pulse ==
    (!register_lock_bit && $past(req.wdata[7]) ? $past(sync_member) : 4'h0))
    else $error("bad load");
  AST_CLEAR: assert property (w20 && req.wdata[6] |=>
    output_clear_pulse == !register_lock_bit) else $error("bad clear pulse");
  AST_SNAP: assert property (w20 && req.wdata[4] ##1
    !register_lock_bit && !w20 |-> snapshot_start ##1 !snapshot_start)
    else $error("bad snapshot pulse");
  AST_PROT: assert property ($rose(protect_start) |->
    !register_lock_bit && $past(w20 && req.wdata[3]))
    else $error("protect without write");
  AST_SRST: assert property (w20 |=> soft_reset_pulse ==
    (!register_lock_bit && $past(req.wdata[11:8]) == `QDCC_RESET_KEY))
    else $error("bad reset");
  AST_LOCK: assert property (w20 ##1 register_lock_bit |->
    !sync_load_pulse && !output_clear_pulse && !soft_reset_pulse)
    else $error("locked write ran");
  AST_FLAG: assert property (w21 && !busy[3] && req.wdata[3] ##1
    !register_lock_bit |-> comparator_flag_clear[3])
    else $error("flag clear missing");
  AST_MLO: assert property (w21 && !busy[1] |=> margin_low_trigger[1] ==
    (!register_lock_bit && $past(req.wdata[10]))) else $error("bad low");
  AST_MHI: assert property (w21 && !busy[2] && req.wdata[5] ##1
    !register_lock_bit && !w21 |-> margin_high_trigger[2] ##1
    !margin_high_trigger[2]) else $error("bad high");
  AST_BUSY: assert property (w21 && busy[0] |=> !comparator_flag_clear[0] &&
    !margin_low_trigger[0] && !margin_high_trigger[0]) else $error("busy ran");
  AST_STAT: assert property (req.rd && req.addr == `QDCC_ADDR_STATUS |=>
    rdata == {$past(factory_store_check_fail), $past(user_store_check_fail),
    1'b0, $past(busy), 1'b0, PART_ID, REVISION}) else $error("bad status");

  // Main scenarios reached
  cover property (w20 && req.wdata[7]);
  cover property (w20 ##1 register_lock_bit);
  cover property (w21 && busy[0]);
endmodule

bind qdcc_regs qdcc_regs_chk #(.PART_ID(PART_ID), .REVISION(REVISION))
  qdcc_regs_chk_i (.clk(clk), .rst(rst), .req(req), .rdata(rdata),
  .busy(busy), .sync_member(sync_member),
  .factory_store_check_fail(factory_store_check_fail),
  .user_store_check_fail(user_store_check_fail),
  .register_lock_bit(register_lock_bit), .soft_reset_pulse(soft_reset_pulse),
  .sync_load_pulse(sync_load_pulse), .output_clear_pulse(output_clear_pulse),
  .snapshot_start(snapshot_start), .protect_start(protect_start),
  .comparator_flag_clear(comparator_flag_clear),
  .margin_low_trigger(margin_low_trigger),
  .margin_high_trigger(margin_high_trigger));

// ===== qdcc_host.sv
// Host side of the register port: word writes, reads and unlock.
// Assumes the block takes a strobe at the rising clk edge it is seen on.
module qdcc_host
  import qdcc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic [15:0] rdata,
  output qdcc_req_s        req
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req = '0;

  // Released lines show the inverse, so a stale value cannot pass
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~v};
    #1;
  endtask

  // Read data is taken one cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h5a5a};
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 16'ha5a5};
    #1;
    v = rdata;
  endtask

  // Key first, then the lock-clearing config write
  task automatic unlock(input logic [15:0] cfg);
    wr(8'h20, 16'h5000);
    wr(8'h1f, cfg & 16'hbfff);
  endtask
endmodule

// ===== qdcc_regs_bench.sv
// Self-checking bench for the shared control register block.
// Assumes the host model drives the register port; all else is driven here.
module qdcc_regs_bench import qdcc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [5:0] P_ID  = 6'h15; // Arbitrary value
  localparam logic [1:0] P_REV = 2'h1;  // Arbitrary value

  logic        clk = 1'b0, rst = 1'b1, nv_load_valid = 1'b0, rvalid;
  logic        factory_store_check_fail = 1'b0, user_store_check_fail = 1'b0;
  logic [15:0] rdata, d, nv_load_word = 16'h0000;
  logic [3:0]  busy = 4'h0, sync_member = 4'h0, clear_value_select = 4'h0;
  logic [3:0]  current_powerdown_bit, sync_load_pulse, clear_to_mid;
  logic [3:0]  comparator_flag_clear, margin_low_trigger;
  logic [3:0]  margin_high_trigger, waveform_run_bit;
  logic [7:0]  voltage_powerdown_code;
  logic        window_latch_select, snapshot_row_select, int_ref_enable;
  logic        register_lock_bit, soft_reset_pulse, output_clear_pulse;
  logic        snapshot_start, protect_start, row_read_trigger;
  logic        nv_write_trigger, nv_restore_trigger;
  qdcc_req_s   req;
  int          error_cnt = 0, tests_run = 0;

  always #20 clk = ~clk;

  qdcc_regs #(.PART_ID(P_ID), .REVISION(P_REV)) qdcc_regs_i (
    .clk(clk), .rst(rst), .req(req), .rdata(rdata), .rvalid(rvalid),
    .busy(busy), .sync_member(sync_member),
    .clear_value_select(clear_value_select),
    .factory_store_check_fail(factory_store_check_fail),
    .user_store_check_fail(user_store_check_fail),
    .nv_load_valid(nv_load_valid), .nv_load_word(nv_load_word),
    .window_latch_select(window_latch_select),
    .snapshot_row_select(snapshot_row_select),
    .int_ref_enable(int_ref_enable),
    .voltage_powerdown_code(voltage_powerdown_code),
    .current_powerdown_bit(current_powerdown_bit),
    .register_lock_bit(register_lock_bit),
    .soft_reset_pulse(soft_reset_pulse), .sync_load_pulse(sync_load_pulse),
    .output_clear_pulse(output_clear_pulse), .clear_to_mid(clear_to_mid),
    .snapshot_start(snapshot_start), .protect_start(protect_start),
    .row_read_trigger(row_read_trigger), .nv_write_trigger(nv_write_trigger),
    .nv_restore_trigger(nv_restore_trigger),
    .comparator_flag_clear(comparator_flag_clear),
    .margin_low_trigger(margin_low_trigger),
    .margin_high_trigger(margin_high_trigger),
    .waveform_run_bit(waveform_run_bit));

  qdcc_host qdcc_host_i (.clk(clk), .rdata(rdata), .req(req));

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Config outputs settle one cycle after the register itself
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  // Global trigger pulses placed at their trigger word bit positions
  function automatic logic [15:0] pulses();
    return {8'h00, |sync_load_pulse, output_clear_pulse, 1'b0, snapshot_start,
            protect_start, row_read_trigger, nv_write_trigger,
            nv_restore_trigger};
  endfunction

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    host_i_rd_cfg: qdcc_host_i.rd(8'h1f, d);
    check(d, 16'h0fff);
    check(voltage_powerdown_code, 8'hff);
    check(current_powerdown_bit, 4'hf);
    qdcc_host_i.rd(8'h30, d);
    check(d, 16'h0000);
  endtask
  task automatic t_config();
    qdcc_host_i.wr(8'h1f, 16'hb0e6);
    step();
    check({window_latch_select, snapshot_row_select}, 2'b11);
    check(int_ref_enable, 1'b1);
    check(voltage_powerdown_code, 8'h1b);
    check(current_powerdown_bit, 4'h4);
    qdcc_host_i.wr(8'h1f, 16'h0fff);
    step();
    check({snapshot_row_select, int_ref_enable}, 2'b00);
  endtask
  task automatic t_trig();
    @(posedge clk);
    sync_member <= 4'ha;
    clear_value_select <= 4'h6;
    for (int b = 0; b < 8; b++) begin
      qdcc_host_i.wr(8'h20, 16'h0001 << b);
      check(pulses(), (16'h0001 << b) & 16'hffdf);
      if (b == 7) check(sync_load_pulse, 4'ha);
      if (b == 6) check(clear_to_mid, 4'h6);
      step();
      check(pulses(), 16'h0000);
      qdcc_host_i.rd(8'h20, d);
      check(d, 16'h0000);
    end
    qdcc_host_i.wr(8'h20, 16'h0000);
    check(pulses(), 16'h0000);
  endtask
  task automatic t_srst();
    qdcc_host_i.wr(8'h1f, 16'hb0e6);
    qdcc_host_i.wr(8'h20, 16'h0500);
    check(soft_reset_pulse, 1'b0);
    qdcc_host_i.wr(8'h20, 16'h0a00);
    check(soft_reset_pulse, 1'b1);
    step();
    qdcc_host_i.rd(8'h1f, d);
    check(d, 16'h0fff);
    check(voltage_powerdown_code, 8'hff);
    @(posedge clk);
    nv_load_valid <= 1'b1;
    nv_load_word <= 16'h2fff;
    @(posedge clk);
    nv_load_valid <= 1'b0;
    nv_load_word <= 16'hd000;
    step();
    check(snapshot_row_select, 1'b1);
  endtask
  task automatic t_lock();
    qdcc_host_i.wr(8'h1f, 16'h4fff);
    step();
    check(register_lock_bit, 1'b1);
    qdcc_host_i.wr(8'h20, 16'h0040);
    check(output_clear_pulse, 1'b0);
    qdcc_host_i.wr(8'h1f, 16'h0fff);
    qdcc_host_i.wr(8'h20, 16'h6000);
    qdcc_host_i.wr(8'h1f, 16'h0fff);
    step();
    check(register_lock_bit, 1'b1);
    qdcc_host_i.unlock(16'h0fff);
    step();
    check(register_lock_bit, 1'b0);
    qdcc_host_i.wr(8'h20, 16'h0040);
    check(output_clear_pulse, 1'b1);
  endtask
  task automatic t_chan();
    qdcc_host_i.wr(8'h21, 16'h8429);
    check(comparator_flag_clear, 4'h9);
    check(margin_low_trigger, 4'h2);
    check(margin_high_trigger, 4'h4);
    step();
    check(waveform_run_bit, 4'h8);
    qdcc_host_i.rd(8'h21, d);
    check(d, 16'h0001);
    @(posedge clk);
    busy <= 4'h1;
    qdcc_host_i.wr(8'h21, 16'hf000);
    check(comparator_flag_clear | margin_low_trigger, 4'h0);
    step();
    check(waveform_run_bit, 4'h0);
    @(posedge clk);
    busy <= 4'h0;
    qdcc_host_i.wr(8'h21, 16'h1000);
    step();
    check(waveform_run_bit, 4'h1);
  endtask
  task automatic t_status();
    @(posedge clk);
    factory_store_check_fail <= 1'b1;
    busy <= 4'h5;
    qdcc_host_i.rd(8'h22, d);
    check(rvalid, 1'b1);
    check(d, {2'b10, 1'b0, 4'h5, 1'b0, P_ID, P_REV});
    @(posedge clk);
    factory_store_check_fail <= 1'b0;
    user_store_check_fail <= 1'b1;
    busy <= 4'ha;
    qdcc_host_i.rd(8'h22, d);
    check(d, {2'b01, 1'b0, 4'ha, 1'b0, P_ID, P_REV});
  endtask

  // ----------------------------------------------------------------
  // Sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_config();
    t_trig();
    t_srst();
    t_lock();
    t_chan();
    t_status();
    tally_and_finish();
  end

  // Whole run needs about a hundred cycles; this bound is generous
  initial begin
    repeat (4000) @(posedge clk);
    error_cnt++;
    tally_and_finish();
  end
endmodule
